// ===== core/dfcr_top.sv
// Local design decisions: the address-and-strobe port and the address map.
`timescale 1ns/1ns
// Overview of operation
// - Writing one to a channel's global clear bit clears all four of its flags.
// - Writing one to a complete clear bit clears only that complete flag.
// - Writing one to a half clear bit clears only that half flag.
// - Writing one to an error clear bit clears only that error flag.
// - Clear bits come from software writes; zero bits leave flags unchanged.
// - Clear word holds eight nibbles: global, complete, half, error per channel.
// - Channel groups start at 0xA0000008, twenty bytes apart, last at 0xA0000094.
// - Status flags are set only by hardware events; software cannot set them.
// - Any error, half or complete event also sets the channel's global flag.
module dfcr_top
  import dfcr_pkg::*;
(
  // Clock and reset
  input wire logic i_ref_clk,
  input wire logic i_sys_rst,
  // Register port
  input wire logic [ADDR_W-1:0] i_addr,
  input wire logic [REG_W-1:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [REG_W-1:0] o_rdata,
  // Channel events, one-cycle pulses
  input wire logic [NUM_CHAN-1:0] i_evt_cmpl,
  input wire logic [NUM_CHAN-1:0] i_evt_half,
  input wire logic [NUM_CHAN-1:0] i_evt_err,
  // Interrupt
  output logic o_irq,
  // Channel group access strobes
  output logic o_grp_wr,
  output logic o_grp_rd,
  output logic [CHAN_W-1:0] o_grp_chan,
  output logic [WORD_IDX_W-1:0] o_grp_word,
  output logic [REG_W-1:0] o_grp_wdata
);

  // ==========================================================================
  // Address decode
  logic hit_status;
  logic hit_clear;
  logic hit_irq_en;
  dfcr_grp_sel_t grp_sel;

  assign hit_status = (i_addr == STATUS_ADDR);
  assign hit_clear = (i_addr == CLEAR_ADDR);
  assign hit_irq_en = (i_addr == IRQ_EN_ADDR);

  dfcr_grp_decode u_grp_decode (
    .i_addr(i_addr),
    .o_sel(grp_sel)
  );

  // ==========================================================================
  // Clear strobes: only a write to the clear word produces them
  logic clr_wr;
  logic [REG_W-1:0] clr_vec;

  assign clr_wr = i_wr & hit_clear;
  assign clr_vec = clr_wr ? i_wdata : READ_ZERO;

  // ==========================================================================
  // Per-channel flag holders
  logic [REG_W-1:0] status_vec;
  logic [REG_W-1:0] status_nxt;

  for (genvar n = 0; n < NUM_CHAN; n++) begin : g_chan
    dfcr_flags_t flags;
    dfcr_flags_t flags_nxt;

    dfcr_chan_flags u_flags (
      .i_ref_clk(i_ref_clk),
      .i_sys_rst(i_sys_rst),
      .i_evt_cmpl(i_evt_cmpl[n]),
      .i_evt_half(i_evt_half[n]),
      .i_evt_err(i_evt_err[n]),
      .i_clr(dfcr_nibble(clr_vec, CHAN_W'(n))),
      .o_flags(flags),
      .o_flags_nxt(flags_nxt)
    );

    assign status_vec[FLAG_W*n +: FLAG_W] = flags;
    assign status_nxt[FLAG_W*n +: FLAG_W] = flags_nxt;
  end

  // ==========================================================================
  // Interrupt enable, same layout as the status word
  logic [REG_W-1:0] irq_en_r;
  logic [REG_W-1:0] irq_en_nxt;

  assign irq_en_nxt = (i_wr && hit_irq_en) ? i_wdata : irq_en_r;

  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      irq_en_r <= IRQ_EN_RST;
    end else begin
      irq_en_r <= irq_en_nxt;
    end
  end

  // Built from next-state values so the level tracks the flags with no lag
  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      o_irq <= 1'b0;
    end else begin
      o_irq <= |(status_nxt & irq_en_nxt);
    end
  end

  // ==========================================================================
  // Read data: valid only in the cycle after the read strobe
  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      o_rdata <= READ_ZERO;
    end else if (i_rd) begin
      if (hit_status) begin
        o_rdata <= status_vec;
      end else if (hit_irq_en) begin
        o_rdata <= irq_en_r;
      end else begin
        // Clear word, channel groups and holes all read as zero here
        o_rdata <= READ_ZERO;
      end
    end else begin
      o_rdata <= READ_ZERO;
    end
  end

  // ==========================================================================
  // Channel group strobes toward the channel register banks
  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      o_grp_wr <= 1'b0;
      o_grp_rd <= 1'b0;
    end else begin
      o_grp_wr <= i_wr & grp_sel.hit;
      o_grp_rd <= i_rd & grp_sel.hit;
    end
  end

  // Selection and data only change with an accepted group access
  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      o_grp_chan <= '0;
      o_grp_word <= '0;
      o_grp_wdata <= READ_ZERO;
    end else if ((i_wr || i_rd) && grp_sel.hit) begin
      o_grp_chan <= grp_sel.chan;
      o_grp_word <= grp_sel.word;
      o_grp_wdata <= i_wr ? i_wdata : READ_ZERO;
    end
  end

  // ==========================================================================
  // Checks
  logic [REG_W-1:0] evt_any_vec;

  always_comb begin
    evt_any_vec = READ_ZERO;
    for (int n = 0; n < NUM_CHAN; n++) begin
      evt_any_vec[FLAG_W*n +: FLAG_W] = {FLAG_W{i_evt_cmpl[n] | i_evt_half[n] | i_evt_err[n]}};
    end
  end

  clr_reads_zero_a: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
    i_rd && hit_clear |=> o_rdata == READ_ZERO)
    else $error("clear word did not read as zero");

  clr_same_edge_a: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
    clr_wr && i_wdata == {NUM_CHAN{4'h1}} && evt_any_vec == READ_ZERO
      |=> status_vec == STATUS_RST)
    else $error("clear did not act at the write edge");

  status_read_a: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
    i_rd && hit_status |=> o_rdata == $past(status_vec))
    else $error("status read returned wrong data");

  rdata_idle_a: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
    !i_rd |=> o_rdata == READ_ZERO)
    else $error("read data stood beyond its cycle");

  top_lane_a: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
    clr_wr && i_wdata[REG_W-1 -: FLAG_W] == NIBBLE_ALL &&
      evt_any_vec[REG_W-1 -: FLAG_W] == NIBBLE_ZERO
      |=> status_vec[REG_W-1 -: FLAG_W] == NIBBLE_ZERO)
    else $error("top nibble did not clear channel seven");

  lane_isolate_a: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
    clr_wr && i_wdata[FLAG_W-1:0] == NIBBLE_ZERO && !i_evt_cmpl[0] &&
      !i_evt_half[0] && !i_evt_err[0]
      |=> $stable(status_vec[FLAG_W-1:0]))
    else $error("other lanes disturbed channel zero");

  no_sw_set_a: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
    evt_any_vec == READ_ZERO |=> (status_vec & ~$past(status_vec)) == READ_ZERO)
    else $error("status bit set without an event");

  grp_last_a: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
    i_wr && i_addr == CHAN7_BASE |=> o_grp_wr && o_grp_chan == CHAN_LAST &&
      o_grp_word == '0)
    else $error("last channel group misplaced");

  grp_first_a: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
    i_rd && i_addr == CHAN0_BASE + GRP_SPAN - 32'h0000_0004 |=> o_grp_rd &&
      o_grp_chan == '0 && o_grp_word == GRP_WORD_LAST)
    else $error("first channel group misplaced");

  grp_gap_a: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
    i_wr && i_addr == CHAN0_BASE + GRP_SPAN |=> !o_grp_wr)
    else $error("gap word decoded as a group register");

  irq_level_a: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
    o_irq == |(status_vec & irq_en_r))
    else $error("interrupt level disagrees with enabled flags");

endmodule

// ===== core/dfcr_pkg.sv
package dfcr_pkg;

  // ==========================================================================
  // Sizes
  localparam int NUM_CHAN = 8;
  localparam int FLAG_W = 4;
  localparam int REG_W = 32;
  localparam int ADDR_W = 32;
  localparam int CHAN_W = 3;
  localparam int WORD_IDX_W = 2;
  localparam int WORD_LSB = 2;
  localparam int BYTE_OFF_W = 2;

  // ==========================================================================
  // Address map
  localparam logic [ADDR_W-1:0] STATUS_ADDR = 32'hA000_0000;
  localparam logic [ADDR_W-1:0] CLEAR_ADDR = 32'hA000_0004;
  localparam logic [ADDR_W-1:0] CHAN0_BASE = 32'hA000_0008;
  localparam logic [ADDR_W-1:0] CHAN_STRIDE = 32'h0000_0014;
  localparam logic [ADDR_W-1:0] CHAN7_BASE = 32'hA000_0094;
  localparam logic [ADDR_W-1:0] GRP_SPAN = 32'h0000_0010;
  localparam logic [ADDR_W-1:0] IRQ_EN_ADDR = 32'hA000_00A8;
  localparam logic [BYTE_OFF_W-1:0] WORD_ALIGN = 2'h0;
  localparam logic [CHAN_W-1:0] CHAN_LAST = 3'h7;
  localparam logic [WORD_IDX_W-1:0] GRP_WORD_LAST = 2'h3;

  // ==========================================================================
  // Flag layout inside one channel nibble
  localparam int FLD_ANY = 0;
  localparam int FLD_CMPL = 1;
  localparam int FLD_HALF = 2;
  localparam int FLD_ERR = 3;

  // ==========================================================================
  // Reset values
  localparam logic [REG_W-1:0] STATUS_RST = 32'h0000_0000;
  localparam logic [REG_W-1:0] IRQ_EN_RST = 32'h0000_0000;
  localparam logic [REG_W-1:0] READ_ZERO = 32'h0000_0000;
  localparam logic [FLAG_W-1:0] NIBBLE_ZERO = 4'h0;
  localparam logic [FLAG_W-1:0] NIBBLE_ALL = 4'hF;

  // ==========================================================================
  // Types
  typedef struct packed {
    logic err;
    logic half;
    logic cmpl;
    logic any;
  } dfcr_flags_t;

  typedef struct packed {
    logic hit;
    logic [CHAN_W-1:0] chan;
    logic [WORD_IDX_W-1:0] word;
  } dfcr_grp_sel_t;

  typedef struct packed {
    logic [NUM_CHAN-1:0] err;
    logic [NUM_CHAN-1:0] half;
    logic [NUM_CHAN-1:0] cmpl;
  } dfcr_events_t;

  // ==========================================================================
  // Helpers
  function automatic logic [ADDR_W-1:0] dfcr_chan_base(input logic [CHAN_W-1:0] n);
    return ADDR_W'(CHAN0_BASE + CHAN_STRIDE * ADDR_W'(n));
  endfunction

  function automatic dfcr_flags_t dfcr_nibble(input logic [REG_W-1:0] v,
                                              input logic [CHAN_W-1:0] n);
    return dfcr_flags_t'(v[FLAG_W*n +: FLAG_W]);
  endfunction

endpackage

// ===== core/dfcr_chan_flags.sv
`timescale 1ns/1ns
module dfcr_chan_flags
  import dfcr_pkg::*;
(
  // Clock and reset
  input wire logic i_ref_clk,
  input wire logic i_sys_rst,
  // Hardware events, one-cycle pulses
  input wire logic i_evt_cmpl,
  input wire logic i_evt_half,
  input wire logic i_evt_err,
  // Software clear strobes for this channel
  input wire dfcr_flags_t i_clr,
  // Flag state
  output dfcr_flags_t o_flags,
  output dfcr_flags_t o_flags_nxt
);

  // ==========================================================================
  // Flag update: an event in the clearing cycle wins
  logic any_evt;
  dfcr_flags_t flags_r;
  dfcr_flags_t flags_nxt;

  assign any_evt = i_evt_cmpl | i_evt_half | i_evt_err;

  always_comb begin
    flags_nxt.cmpl = i_evt_cmpl | (flags_r.cmpl & ~(i_clr.cmpl | i_clr.any));
    flags_nxt.half = i_evt_half | (flags_r.half & ~(i_clr.half | i_clr.any));
    flags_nxt.err = i_evt_err | (flags_r.err & ~(i_clr.err | i_clr.any));
    flags_nxt.any = any_evt | (flags_r.any & ~i_clr.any);
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      flags_r <= dfcr_flags_t'(NIBBLE_ZERO);
    end else begin
      flags_r <= flags_nxt;
    end
  end

  assign o_flags = flags_r;
  assign o_flags_nxt = flags_nxt;

  // ==========================================================================
  // Checks
  glob_clear_a: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
    i_clr.any && !any_evt |=> o_flags == dfcr_flags_t'(NIBBLE_ZERO))
    else $error("global clear left a flag set");

  cmpl_only_a: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
    i_clr == dfcr_flags_t'(4'h2) && !any_evt |=>
      !o_flags.cmpl && o_flags.any == $past(o_flags.any) &&
      o_flags.half == $past(o_flags.half) && o_flags.err == $past(o_flags.err))
    else $error("complete clear touched another flag");

  half_only_a: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
    i_clr == dfcr_flags_t'(4'h4) && !any_evt |=>
      !o_flags.half && o_flags.any == $past(o_flags.any) &&
      o_flags.cmpl == $past(o_flags.cmpl) && o_flags.err == $past(o_flags.err))
    else $error("half clear touched another flag");

  err_only_a: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
    i_clr == dfcr_flags_t'(4'h8) && !any_evt |=>
      !o_flags.err && o_flags.any == $past(o_flags.any) &&
      o_flags.cmpl == $past(o_flags.cmpl) && o_flags.half == $past(o_flags.half))
    else $error("error clear touched another flag");

  zero_keep_a: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
    i_clr == dfcr_flags_t'(NIBBLE_ZERO) && !any_evt |=> $stable(o_flags))
    else $error("flags changed without clear or event");

  set_wins_a: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
    i_evt_cmpl && i_clr.any |=> o_flags.cmpl && o_flags.any)
    else $error("event lost against a clear");

  hw_only_a: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
    $rose(o_flags.err) |-> $past(i_evt_err))
    else $error("error flag rose without an event");

  any_follow_a: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
    (i_evt_half || i_evt_err) ##1 !i_clr.any |-> ##1 o_flags.any)
    else $error("global flag missed an event");

endmodule

// ===== core/dfcr_grp_decode.sv
`timescale 1ns/1ns
module dfcr_grp_decode
  import dfcr_pkg::*;
(
  // Bus address
  input wire logic [ADDR_W-1:0] i_addr,
  // Channel group hit
  output dfcr_grp_sel_t o_sel
);

  // ==========================================================================
  // Wrapped subtraction rejects addresses below a base with one compare
  always_comb begin
    logic [ADDR_W-1:0] off;
    off = '0;
    o_sel = '0;
    for (int n = 0; n < NUM_CHAN; n++) begin
      off = i_addr - dfcr_chan_base(CHAN_W'(n));
      if (off < GRP_SPAN && off[BYTE_OFF_W-1:0] == WORD_ALIGN) begin
        o_sel.hit = 1'b1;
        o_sel.chan = CHAN_W'(n);
        o_sel.word = off[WORD_LSB +: WORD_IDX_W];
      end
    end
  end

endmodule

// ===== verif/tb_dma_flag_clear_register.sv
`timescale 1ns/1ns
module tb_dma_flag_clear_register;
  import dfcr_pkg::*;

  // ==========================================================================
  // Stimulus and design hookup
  logic i_ref_clk = 1'b0;
  logic i_sys_rst = 1'b1;
  logic [ADDR_W-1:0] i_addr = 32'h0000_0000;
  logic [REG_W-1:0] i_wdata = 32'h0000_0000;
  logic i_wr = 1'b0;
  logic i_rd = 1'b0;
  logic [NUM_CHAN-1:0] i_evt_cmpl = 8'h00;
  logic [NUM_CHAN-1:0] i_evt_half = 8'h00;
  logic [NUM_CHAN-1:0] i_evt_err = 8'h00;
  logic [REG_W-1:0] o_rdata;
  logic o_irq;
  logic o_grp_wr;
  logic o_grp_rd;
  logic [CHAN_W-1:0] o_grp_chan;
  logic [WORD_IDX_W-1:0] o_grp_word;
  logic [REG_W-1:0] o_grp_wdata;
  int err_count = 0;
  int compares = 0;
  logic [REG_W-1:0] exp_stat;
  logic [ADDR_W-1:0] grp_addr;

  dfcr_top dut (
    .i_ref_clk(i_ref_clk), .i_sys_rst(i_sys_rst), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_evt_cmpl(i_evt_cmpl),
    .i_evt_half(i_evt_half), .i_evt_err(i_evt_err), .o_irq(o_irq), .o_grp_wr(o_grp_wr),
    .o_grp_rd(o_grp_rd), .o_grp_chan(o_grp_chan), .o_grp_word(o_grp_word),
    .o_grp_wdata(o_grp_wdata)
  );

  initial begin
    forever #25 i_ref_clk = ~i_ref_clk;
  end

  // ==========================================================================
  // Bus and check tasks
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch at %0t: got %h exp %h", $time, got, exp);
    end
  endtask

  // Returns just after the taking edge, so registered answers are settled
  task automatic bus_wr(input logic [31:0] a, input logic [31:0] d);
    @(posedge i_ref_clk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_ref_clk);
    i_wr <= 1'b0;
    #1;
  endtask

  task automatic bus_rd(input logic [31:0] a, output logic [31:0] d);
    @(posedge i_ref_clk);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_ref_clk);
    i_rd <= 1'b0;
    #1;
    d = o_rdata;
  endtask

  task automatic rd_chk(input logic [31:0] a, input logic [31:0] exp);
    logic [31:0] d;
    bus_rd(a, d);
    chk(d, exp);
  endtask

  task automatic evt(input logic [7:0] c, input logic [7:0] h, input logic [7:0] e);
    @(posedge i_ref_clk);
    i_evt_cmpl <= c;
    i_evt_half <= h;
    i_evt_err <= e;
    @(posedge i_ref_clk);
    i_evt_cmpl <= 8'h00;
    i_evt_half <= 8'h00;
    i_evt_err <= 8'h00;
    #1;
  endtask

  task automatic wrap_up();
    $display("compares %0d mismatches %0d", compares, err_count);
    if (err_count == 0 && compares > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // Bounded run; a hang counts against the run
  initial begin
    repeat (20000) @(posedge i_ref_clk);
    err_count++;
    $display("timeout at %0t", $time);
    wrap_up();
  end

  // ==========================================================================
  // Tests
  initial begin
    repeat (6) @(posedge i_ref_clk);
    i_sys_rst <= 1'b0;
    rd_chk(STATUS_ADDR, 32'h0000_0000);
    @(posedge i_ref_clk);
    #1;
    chk(o_rdata, 32'h0000_0000);
    rd_chk(CLEAR_ADDR, 32'h0000_0000);
    rd_chk(IRQ_EN_ADDR, 32'h0000_0000);
    chk(32'(o_irq), 32'h0000_0000);
    bus_wr(STATUS_ADDR, 32'hFFFF_FFFF);
    rd_chk(STATUS_ADDR, 32'h0000_0000);
    $display("test reset_and_readonly done");

    // Every event kind on every channel also raises that channel's global flag
    for (int n = 0; n < 8; n++) begin
      for (int t = 1; t < 4; t++) begin
        evt(8'(t == 1) << n, 8'(t == 2) << n, 8'(t == 3) << n);
        rd_chk(STATUS_ADDR, (32'h0000_0001 | (32'h0000_0001 << t)) << (4 * n));
        bus_wr(CLEAR_ADDR, 32'h0000_0001 << (4 * n));
      end
    end
    $display("test event_set done");

    // Single clears across all 32 positions; zero bits must leave flags alone
    evt(8'hFF, 8'hFF, 8'hFF);
    exp_stat = 32'hFFFF_FFFF;
    bus_wr(CLEAR_ADDR, 32'h0000_0000);
    rd_chk(STATUS_ADDR, exp_stat);
    bus_wr(STATUS_ADDR, 32'h0000_0000);
    rd_chk(STATUS_ADDR, exp_stat);
    for (int n = 0; n < 8; n++) begin
      for (int f = 1; f < 4; f++) begin
        bus_wr(CLEAR_ADDR, 32'h0000_0001 << (4 * n + f));
        exp_stat = exp_stat & ~(32'h0000_0001 << (4 * n + f));
        rd_chk(STATUS_ADDR, exp_stat);
      end
      bus_wr(CLEAR_ADDR, 32'h0000_0001 << (4 * n));
      exp_stat = exp_stat & ~(32'h0000_0001 << (4 * n));
      rd_chk(STATUS_ADDR, exp_stat);
    end
    evt(8'hFF, 8'hFF, 8'hFF);
    exp_stat = 32'hFFFF_FFFF;
    for (int n = 7; n >= 0; n--) begin
      bus_wr(CLEAR_ADDR, 32'h0000_0001 << (4 * n));
      exp_stat = exp_stat & ~(32'h0000_000F << (4 * n));
      rd_chk(STATUS_ADDR, exp_stat);
    end
    // Whole-nibble clear on the top lane, then every global bit in one write
    evt(8'hFF, 8'hFF, 8'hFF);
    bus_wr(CLEAR_ADDR, 32'hF000_0000);
    rd_chk(STATUS_ADDR, 32'h0FFF_FFFF);
    bus_wr(CLEAR_ADDR, 32'h1111_1111);
    rd_chk(STATUS_ADDR, 32'h0000_0000);
    $display("test clear_layout done");

    // Event and global clear in the same cycle: the new event survives
    @(posedge i_ref_clk);
    i_wr <= 1'b1;
    i_addr <= CLEAR_ADDR;
    i_wdata <= 32'h0000_000F;
    i_evt_cmpl <= 8'h01;
    @(posedge i_ref_clk);
    i_wr <= 1'b0;
    i_evt_cmpl <= 8'h00;
    #1;
    rd_chk(STATUS_ADDR, 32'h0000_0003);
    bus_wr(CLEAR_ADDR, 32'h0000_0001);
    rd_chk(STATUS_ADDR, 32'h0000_0000);
    $display("test set_beats_clear done");

    // Interrupt: masked, enabled, cleared
    evt(8'h08, 8'h00, 8'h00);
    chk(32'(o_irq), 32'h0000_0000);
    bus_wr(IRQ_EN_ADDR, 32'h0000_2000);
    chk(32'(o_irq), 32'h0000_0001);
    rd_chk(IRQ_EN_ADDR, 32'h0000_2000);
    bus_wr(CLEAR_ADDR, 32'h0000_2000);
    chk(32'(o_irq), 32'h0000_0000);
    rd_chk(STATUS_ADDR, 32'h0000_1000);
    bus_wr(IRQ_EN_ADDR, 32'h0000_1000);
    chk(32'(o_irq), 32'h0000_0001);
    bus_wr(CLEAR_ADDR, 32'h0000_1000);
    chk(32'(o_irq), 32'h0000_0000);
    $display("test interrupt done");

    // Channel group placement: twenty bytes apart from the first base
    for (int n = 0; n < 8; n++) begin
      for (int w = 0; w < 4; w++) begin
        grp_addr = 32'hA000_0008 + 32'(20 * n) + 32'(4 * w);
        bus_wr(grp_addr, 32'h5A00_0000 | 32'(n * 16 + w));
        chk({o_grp_wr, 26'h000_0000, o_grp_chan, o_grp_word}, {1'b1, 26'h0, 3'(n), 2'(w)});
        chk(o_grp_wdata, 32'h5A00_0000 | 32'(n * 16 + w));
        @(posedge i_ref_clk);
        #1;
        chk(32'(o_grp_wr), 32'h0000_0000);
      end
      bus_rd(32'hA000_0008 + 32'(20 * n) + 32'h0000_000C, exp_stat);
      chk({o_grp_rd, 26'h000_0000, o_grp_chan, o_grp_word}, {1'b1, 26'h0, 3'(n), 2'h3});
      chk(exp_stat, 32'h0000_0000);
      rd_chk(32'hA000_0008 + 32'(20 * n) + 32'h0000_0010, 32'h0000_0000);
      chk(32'(o_grp_rd), 32'h0000_0000);
      // The gap word after each group must not strobe a write either
      bus_wr(32'hA000_0008 + 32'(20 * n) + 32'h0000_0010, 32'hFFFF_FFFF);
      chk(32'(o_grp_wr), 32'h0000_0000);
    end
    rd_chk(32'hA000_00B0, 32'h0000_0000);
    chk(32'(o_grp_rd), 32'h0000_0000);
    $display("test group_map done");

    // Reset in mid-run drops flags and enables
    evt(8'hFF, 8'h00, 8'h00);
    bus_wr(IRQ_EN_ADDR, 32'hFFFF_FFFF);
    chk(32'(o_irq), 32'h0000_0001);
    @(posedge i_ref_clk);
    i_sys_rst <= 1'b1;
    repeat (2) @(posedge i_ref_clk);
    i_sys_rst <= 1'b0;
    #1;
    chk(32'(o_irq), 32'h0000_0000);
    rd_chk(STATUS_ADDR, 32'h0000_0000);
    rd_chk(IRQ_EN_ADDR, 32'h0000_0000);
    $display("test mid_reset done");
    wrap_up();
  end
endmodule
